/* common/tfer_regs.vh */
// Constants for the translation fault event record block.
// What this block does
// - Descriptor output beyond size limit: type 0x11.
// - Early table base error: configuration error only.
// - Stage 1 bypass out of range: address fault.
// - Bypass address fault: class IN, stage zero.
// - Accessed flag clear in leaf: type 0x12.
// - Hardware update sets flag, suppresses access fault.
// - Record carries overridden attributes; writes clear instr.
// - Records with stall set never merge.
// - Merge compare ignores incoming address bits 11:0.
// - Intermediate address bits 51:48 written zero.
// - Stage 1 class IN, stage 2 given class.
// - Permission type 0x13, walk read flag for TT.
`ifndef TFER_REGS_VH
`define TFER_REGS_VH
// Register byte offsets on the bus.
`define TFER_OFF_CTRL 5'h00
`define TFER_OFF_STATUS 5'h04
`define TFER_OFF_MASK 5'h08
`define TFER_OFF_COUNT 5'h0C
`define TFER_OFF_LAST 5'h10
// Control bits and reset value.
`define TFER_CTRL_EN 0
`define TFER_CTRL_HWUPD 1
`define TFER_CTRL_RST 2'h1
// Status and mask bits.
`define TFER_ST_ASZ 0
`define TFER_ST_ACC 1
`define TFER_ST_PERM 2
`define TFER_ST_CFG 3
`define TFER_ST_MERGE 4
`define TFER_ST_RST 5'h00
`define TFER_MASK_RST 5'h00
// Event type codes.
`define TFER_TYPE_ASZ 8'h11
`define TFER_TYPE_ACC 8'h12
`define TFER_TYPE_PERM 8'h13
// Outcome of one checked walk result.
`define TFER_K_NONE 3'h0
`define TFER_K_CFG 3'h1
`define TFER_K_ASZ 3'h2
`define TFER_K_ACC 3'h3
`define TFER_K_PERM 3'h4
`define TFER_K_AFUPD 3'h5
// Access category codes.
`define TFER_CLASS_CD 2'h0
`define TFER_CLASS_TT 2'h1
`define TFER_CLASS_IN 2'h2
// Field positions in word 0, word 2 and word 3.
`define TFER_W0_SSV 11
`define TFER_W2_STALL 31
`define TFER_W3_PRIV 0
`define TFER_W3_INSTR 1
`define TFER_W3_READ 2
`define TFER_W3_NS 3
`define TFER_W3_STAGE 7
`define TFER_W3_CLASS_LO 8
`define TFER_W3_WALKRD 10
`endif

/* hdl/tfer_classify.v */
// Decides which event a checked walk result produces.
`timescale 1ns/10ps
`include "tfer_regs.vh"
module tfer_classify (
	input wire ttb_err_i,
	input wire bypass_i,
	input wire stage2_i,
	input wire [63:0] in_addr_i,
	input wire [5:0] impl_bits_i,
	input wire [51:0] desc_oa_i,
	input wire [5:0] size_bits_i,
	input wire leaf_i,
	input wire accessed_flag_i,
	input wire hw_update_i,
	input wire perm_fault_i,
	output reg [2:0] kind_o
);
	// Address above its limit when any bit at or over the limit is set.
	wire byp_over = |(in_addr_i >> impl_bits_i);
	wire oa_over = |(desc_oa_i >> size_bits_i);

	// Checks in priority order; the first hit decides.
	always @* begin
		kind_o = `TFER_K_NONE;
		if (ttb_err_i) begin
			kind_o = `TFER_K_CFG;
		end else if (bypass_i && !stage2_i) begin
			if (byp_over) begin
				kind_o = `TFER_K_ASZ;
			end
		end else if (oa_over) begin
			kind_o = `TFER_K_ASZ;
		end else if (leaf_i && !accessed_flag_i) begin
			if (hw_update_i) begin
				kind_o = `TFER_K_AFUPD;
			end else begin
				kind_o = `TFER_K_ACC;
			end
		end else if (perm_fault_i) begin
			kind_o = `TFER_K_PERM;
		end
	end
endmodule

/* hdl/tfer_merge.v */
// Remembers the last record and flags an identical follower.
`timescale 1ns/10ps
`include "tfer_regs.vh"
module tfer_merge (
	input wire clk_i,
	input wire rst_i,
	input wire [255:0] rec_i,
	input wire load_i,
	output wire dup_o
);
	// Last stored record with the low address bits cleared.
	reg [255:0] last;
	// Set once a record has been stored.
	reg have;
	wire [255:0] keyed = {rec_i[255:140], 12'h000, rec_i[127:0]};
	assign dup_o = have && (keyed == last) && !rec_i[64 + `TFER_W2_STALL];

	// Capture each emitted record.
	always @(posedge clk_i) begin
		if (rst_i) begin
			last <= 256'h0;
			have <= 1'b0;
		end else if (load_i) begin
			last <= keyed;
			have <= 1'b1;
		end
	end
endmodule

/* hdl/tfer_top.v */
// Fault checks, record packing, merging and registers of the block.
`timescale 1ns/10ps
`include "tfer_regs.vh"
module tfer_top (
	input wire clk_i,
	input wire rst_i,
	// Wishbone slave.
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [4:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	// Walk result from the translation logic.
	input wire req_valid_i,
	output wire req_ready_o,
	input wire req_ttb_err_i,
	input wire req_from_ste_i,
	input wire req_bypass_i,
	input wire req_stage2_i,
	input wire [1:0] req_class_i,
	input wire req_leaf_i,
	input wire req_accessed_flag_i,
	input wire req_perm_fault_i,
	input wire req_walk_write_i,
	input wire [51:0] req_desc_oa_i,
	input wire [5:0] req_size_bits_i,
	input wire [5:0] req_impl_bits_i,
	input wire req_read_i,
	input wire req_instr_i,
	input wire req_priv_i,
	input wire req_ns_i,
	input wire req_stall_i,
	input wire [31:0] req_stream_i,
	input wire req_ssv_i,
	input wire [19:0] req_sub_stream_i,
	input wire [63:0] req_in_addr_i,
	input wire [51:0] req_ipa_i,
	// Record towards the event queue.
	output reg rec_valid_o,
	input wire rec_ready_i,
	output reg [255:0] rec_data_o,
	// Configuration errors and flag updates.
	output reg cfg_err_o,
	output reg cfg_err_ste_o,
	output reg af_update_o,
	output wire irq_o
);
	// Hardware table update is built into this block.
	parameter HW_UPDATE_SUPPORTED = 1'b1;

	// Software control bits.
	reg [1:0] ctrl;
	// Sticky event bits.
	reg [4:0] status;
	// Interrupt mask bits.
	reg [4:0] mask;
	// Count of emitted records.
	reg [15:0] emit_count;
	// Count of merged records.
	reg [15:0] merge_count;
	// Type code of the last emitted record.
	reg [7:0] last_type;

	// Outcome of the current walk result.
	wire [2:0] kind;
	// High when the new record matches the last one.
	wire dup;
	// Packed record for the current walk result.
	reg [255:0] next_rec;
	// Type code for the current record.
	reg [7:0] next_type;
	// Intermediate address placed in the record.
	reg [51:0] next_ipa;
	// Category placed in the record.
	reg [1:0] next_class;

	// A result is taken only while no record waits.
	assign req_ready_o = !rec_valid_o;
	// Taken walk result.
	wire take = req_valid_i && req_ready_o;
	// Enabled block with a taken result.
	wire live = take && ctrl[`TFER_CTRL_EN];
	// Result that forms a record.
	wire is_rec = (kind == `TFER_K_ASZ) || (kind == `TFER_K_ACC) || (kind == `TFER_K_PERM);
	// Record sent to the queue.
	wire emit = live && is_rec && !dup;
	// Record folded into the previous one.
	wire merged = live && is_rec && dup;
	// Hardware update allowed by build and software.
	wire hw_upd = HW_UPDATE_SUPPORTED && ctrl[`TFER_CTRL_HWUPD];

	// Selects the event for the walk result.
	tfer_classify u_classify (
		.ttb_err_i(req_ttb_err_i),
		.bypass_i(req_bypass_i),
		.stage2_i(req_stage2_i),
		.in_addr_i(req_in_addr_i),
		.impl_bits_i(req_impl_bits_i),
		.desc_oa_i(req_desc_oa_i),
		.size_bits_i(req_size_bits_i),
		.leaf_i(req_leaf_i),
		.accessed_flag_i(req_accessed_flag_i),
		.hw_update_i(hw_upd),
		.perm_fault_i(req_perm_fault_i),
		.kind_o(kind)
	);

	// Detects a record identical to the last emitted one.
	tfer_merge u_merge (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.rec_i(next_rec),
		.load_i(emit),
		.dup_o(dup)
	);

	// Chooses the type code for the record.
	always @* begin
		case (kind)
			`TFER_K_ASZ: next_type = `TFER_TYPE_ASZ;
			`TFER_K_ACC: next_type = `TFER_TYPE_ACC;
			`TFER_K_PERM: next_type = `TFER_TYPE_PERM;
			default: next_type = 8'h00;
		endcase
	end

	// Fixes category and intermediate address by fault stage.
	always @* begin
		next_class = `TFER_CLASS_IN;
		next_ipa = 52'h0;
		if (req_bypass_i && !req_stage2_i) begin
			next_class = `TFER_CLASS_IN;
			next_ipa = 52'h0;
		end else if (req_stage2_i) begin
			next_class = req_class_i;
			next_ipa = req_ipa_i;
		end
	end

	// Packs the eight record words.
	always @* begin
		next_rec = 256'h0;
		next_rec[7:0] = next_type;
		next_rec[`TFER_W0_SSV] = req_ssv_i;
		next_rec[31:12] = req_sub_stream_i;
		next_rec[63:32] = req_stream_i;
		next_rec[64 + `TFER_W2_STALL] = req_stall_i;
		next_rec[96 + `TFER_W3_PRIV] = req_priv_i;
		next_rec[96 + `TFER_W3_INSTR] = req_instr_i && req_read_i;
		next_rec[96 + `TFER_W3_READ] = req_read_i;
		next_rec[96 + `TFER_W3_NS] = req_ns_i;
		// Stage flag.
		// A stage 2 fault keeps its flag even when stage 1 is bypassed; bypass faults come with stage2 low.
		next_rec[96 + `TFER_W3_STAGE] = req_stage2_i;
		next_rec[97 + `TFER_W3_CLASS_LO] = next_class[1];
		next_rec[96 + `TFER_W3_CLASS_LO] = next_class[0];
		if (kind == `TFER_K_PERM && next_class == `TFER_CLASS_TT) begin
			next_rec[96 + `TFER_W3_WALKRD] = !req_walk_write_i;
		end
		next_rec[191:128] = req_in_addr_i;
		next_rec[223:204] = next_ipa[31:12];
		next_rec[239:224] = next_ipa[47:32];
		next_rec[243:240] = 4'h0;
	end

	// Holds a record until the queue takes it.
	always @(posedge clk_i) begin
		if (rst_i) begin
			rec_valid_o <= 1'b0;
			rec_data_o <= 256'h0;
		end else if (emit) begin
			rec_valid_o <= 1'b1;
			rec_data_o <= next_rec;
		end else if (rec_valid_o && rec_ready_i) begin
			rec_valid_o <= 1'b0;
		end
	end

	// One-cycle pulses for errors and flag updates; cfg_err_ste_o holds the source of the last error.
	always @(posedge clk_i) begin
		if (rst_i) begin
			cfg_err_o <= 1'b0;
			cfg_err_ste_o <= 1'b0;
			af_update_o <= 1'b0;
		end else begin
			cfg_err_o <= live && (kind == `TFER_K_CFG);
			if (live && (kind == `TFER_K_CFG)) begin
				cfg_err_ste_o <= req_from_ste_i;
			end
			af_update_o <= live && (kind == `TFER_K_AFUPD);
		end
	end

	// Event counters and last type code.
	always @(posedge clk_i) begin
		if (rst_i) begin
			emit_count <= 16'h0000;
			merge_count <= 16'h0000;
			last_type <= 8'h00;
		end else begin
			if (emit) begin
				emit_count <= emit_count + 16'h0001;
				last_type <= next_type;
			end
			if (merged) begin
				merge_count <= merge_count + 16'h0001;
			end
		end
	end

	// Event bits raised by the current result.
	reg [4:0] ev;
	always @* begin
		ev = 5'h00;
		ev[`TFER_ST_ASZ] = live && (kind == `TFER_K_ASZ);
		ev[`TFER_ST_ACC] = live && (kind == `TFER_K_ACC);
		ev[`TFER_ST_PERM] = live && (kind == `TFER_K_PERM);
		ev[`TFER_ST_CFG] = live && (kind == `TFER_K_CFG);
		ev[`TFER_ST_MERGE] = merged;
	end

	// Bus request in its first cycle.
	wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	// Word offset of the request.
	wire [4:0] off = {wb_adr_i[4:2], 2'h0};
	// Write with the low byte lane enabled.
	wire wr0 = bus_req && wb_we_i && wb_sel_i[0];
	// Write-one-clear pattern for status.
	wire [4:0] clr = (wr0 && off == `TFER_OFF_STATUS) ? wb_dat_i[4:0] : 5'h00;

	// Control, mask and sticky status registers.
	always @(posedge clk_i) begin
		if (rst_i) begin
			ctrl <= `TFER_CTRL_RST;
			mask <= `TFER_MASK_RST;
			status <= `TFER_ST_RST;
		end else begin
			if (wr0 && off == `TFER_OFF_CTRL) begin
				ctrl <= wb_dat_i[1:0];
			end
			if (wr0 && off == `TFER_OFF_MASK) begin
				mask <= wb_dat_i[4:0];
			end
			// A new event wins over a clear in the same cycle.
			status <= (status & ~clr) | ev;
		end
	end

	// Level interrupt from unmasked sticky bits.
	assign irq_o = |(status & mask);

	// Read data mux; unmapped offsets read zero.
	reg [31:0] next_rdata;
	always @* begin
		next_rdata = 32'h00000000;
		case (off)
			`TFER_OFF_CTRL: next_rdata = {30'h0, ctrl};
			`TFER_OFF_STATUS: next_rdata = {27'h0, status};
			`TFER_OFF_MASK: next_rdata = {27'h0, mask};
			`TFER_OFF_COUNT: next_rdata = {merge_count, emit_count};
			`TFER_OFF_LAST: next_rdata = {24'h0, last_type};
			default: next_rdata = 32'h00000000;
		endcase
	end

	// Answers every request one cycle after it rises.
	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= bus_req;
			if (bus_req && !wb_we_i) begin
				wb_dat_o <= next_rdata;
			end
		end
	end
endmodule

/* verification/tfer_properties.sv */
// Checker on the ports of the fault record block.
`timescale 1ns/10ps
module tfer_properties (
	input logic clk_i,
	input logic rst_i,
	input logic wb_cyc_i,
	input logic wb_stb_i,
	input logic wb_ack_o,
	input logic req_valid_i,
	input logic req_ready_o,
	input logic req_ttb_err_i,
	input logic req_from_ste_i,
	input logic req_bypass_i,
	input logic req_stage2_i,
	input logic req_stall_i,
	input logic [5:0] req_impl_bits_i,
	input logic [63:0] req_in_addr_i,
	input logic rec_valid_o,
	input logic rec_ready_i,
	input logic [255:0] rec_data_o,
	input logic cfg_err_o,
	input logic cfg_err_ste_o,
	input logic af_update_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// A walk result is taken when both sides agree.
	wire take = req_valid_i && req_ready_o;
	a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	a_ready_block: assert property (rec_valid_o |-> !req_ready_o) else $error("ready while pending");
	a_rec_hold: assert property (rec_valid_o && !rec_ready_i |=> rec_valid_o && $stable(rec_data_o))
		else $error("record moved");
	a_cfg_error: assert property (take && req_ttb_err_i |=> cfg_err_o && !rec_valid_o &&
		cfg_err_ste_o == $past(req_from_ste_i)) else $error("config error wrong");
	a_bypass_size: assert property (take && !req_ttb_err_i && req_bypass_i && !req_stage2_i &&
		req_stall_i && (req_in_addr_i >> req_impl_bits_i) != 0 |=> rec_valid_o &&
		rec_data_o[7:0] == 8'h11 && rec_data_o[105:103] == 3'b100) else $error("bypass fault wrong");
	a_instr_write: assert property (rec_valid_o && !rec_data_o[98] |-> !rec_data_o[97])
		else $error("instr on write");
	a_ipa_zero: assert property (rec_valid_o |-> rec_data_o[243:240] == 4'h0) else $error("ipa top set");
	a_af_silent: assert property (af_update_o |-> !rec_valid_o && !cfg_err_o) else $error("af recorded");
	a_type_known: assert property ($rose(rec_valid_o) |-> rec_data_o[7:0] inside {8'h11, 8'h12, 8'h13})
		else $error("bad type");
endmodule

/* verification/tfer_queue_model.sv */
// Event queue model that takes records with random stalls.
`timescale 1ns/10ps
module tfer_queue_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic rec_valid_i,
	output logic rec_ready_o = 1'b0,
	output int taken_o = 0
);
	// Ready is drawn afresh each cycle so records can wait.
	always @(posedge clk_i) begin
		rec_ready_o <= !rst_i && ($urandom % 3 == 0);
		if (rst_i)
			taken_o <= 0;
		else if (rec_valid_i && rec_ready_o)
			taken_o <= taken_o + 1;
	end
endmodule

/* verification/tfer_top_test.sv */
// Self-checking bench for the fault record block.
`timescale 1ns/10ps
module tfer_top_test;
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, a1;
	logic [4:0] adr = 0;
	logic [31:0] dat = 0, q, sid = 0;
	logic v = 0, table_base_address = 0, fste = 0, byp = 0, s2 = 0, leaf = 0, af = 0, perm = 0, ww = 0;
	logic rd = 0, ins = 0, pr = 0, ns = 0, st = 0, sub_stream_valid = 0;
	logic [1:0] cls = 0;
	logic [51:0] oa = 0, intermediate_phys_address = 0;
	logic [5:0] sb = 0, ib = 0;
	logic [19:0] sub = 0;
	logic [63:0] ia = 0;
	logic [7:0] et;
	wire rv, ce, ces, afu, irq, ready, ack, rdy;
	wire [31:0] wdo;
	wire [255:0] rec;
	int failures = 0, checks = 0, recs = 0, i, n;
	tfer_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(wdo), .wb_ack_o(ack),
		.req_valid_i(v), .req_ready_o(ready), .req_ttb_err_i(table_base_address), .req_from_ste_i(fste),
		.req_bypass_i(byp), .req_stage2_i(s2), .req_class_i(cls), .req_leaf_i(leaf),
		.req_accessed_flag_i(af), .req_perm_fault_i(perm), .req_walk_write_i(ww), .req_desc_oa_i(oa),
		.req_size_bits_i(sb), .req_impl_bits_i(ib), .req_read_i(rd), .req_instr_i(ins), .req_priv_i(pr),
		.req_ns_i(ns), .req_stall_i(st), .req_stream_i(sid), .req_ssv_i(sub_stream_valid), .req_sub_stream_i(sub),
		.req_in_addr_i(ia), .req_ipa_i(intermediate_phys_address), .rec_valid_o(rv), .rec_ready_i(rdy), .rec_data_o(rec),
		.cfg_err_o(ce), .cfg_err_ste_o(ces), .af_update_o(afu), .irq_o(irq));
	tfer_queue_model u_q (.clk_i(clk_i), .rst_i(rst_i), .rec_valid_i(rv), .rec_ready_o(rdy), .taken_o());
	initial forever #5 clk_i = ~clk_i;
	task automatic report_and_stop;
		if (failures == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(string nm, logic [63:0] e, logic [63:0] g);
		checks++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// One classic bus cycle, held until ack is sampled.
	task automatic wb(logic w, logic [4:0] a, logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		dat <= d;
		do
			@(posedge clk_i);
		while (ack !== 1'b1);
		q = wdo;
		cyc <= 0;
		stb <= 0;
		#1;
	endtask
	// Offers one walk result once no record is pending.
	task automatic send;
		@(posedge clk_i);
		while (ready !== 1'b1)
			@(posedge clk_i);
		v <= 1;
		@(posedge clk_i);
		v <= 0;
		#1;
	endtask
	// Outcome by priority: 01 config, 02 flag update, 00 nothing.
	function automatic logic [7:0] exp_t(logic hw);
		if (table_base_address)
			return 8'h01;
		if (byp && !s2)
			return ((ia >> ib) != 0) ? 8'h11 : 8'h00;
		if ((oa >> sb) != 0)
			return 8'h11;
		if (leaf && !af)
			return hw ? 8'h02 : 8'h12;
		return perm ? 8'h13 : 8'h00;
	endfunction
	task automatic judge(logic hw);
		et = exp_t(hw);
		recs += et[4];
		chk("record", et[4], rv);
		chk("cfg", et == 8'h01, ce);
		chk("afupd", et == 8'h02, afu);
		if (et == 8'h01)
			chk("ste", fste, ces);
		if (rv) begin
			chk("type", et, rec[7:0]);
			chk("word0", {sub, sub_stream_valid}, rec[31:11]);
			chk("stream", sid, rec[63:32]);
			chk("stall", st, rec[95]);
			chk("attr", {s2, ns, rd, ins & rd, pr}, {rec[103], rec[99:96]});
			chk("class", s2 ? cls : 2'h2, rec[105:104]);
			chk("ipa", s2 ? intermediate_phys_address[47:12] : 36'h0, {rec[239:224], rec[223:204]});
			chk("addr", ia, rec[191:128]);
			chk("res0", 0, rec[243:240]);
			if (et == 8'h13 && s2 && cls == 2'h1)
				chk("walk", !ww, rec[106]);
		end
	endtask
	initial begin
		#500000;
		failures++;
		report_and_stop();
	end
	initial begin
		i = $urandom(32'h4445);
		repeat (20) @(posedge clk_i);
		rst_i <= 0;
		wb(0, 5'h00, 0);
		chk("ctrl", 1, q);
		wb(0, 5'h04, 0);
		chk("status", 0, q);
		wb(0, 5'h08, 0);
		chk("mask", 0, q);
		wb(0, 5'h14, 0);
		chk("unmapped", 0, q);
		repeat (150) begin
			@(posedge clk_i);
			i = $urandom;
			{byp, leaf, af, perm, ww, rd, ins, pr, ns, sub_stream_valid, fste} <= 11'(i);
			s2 <= !i[0] && i[11];
			cls <= i[12] ? 2'h1 : {i[13], 1'b0};
			table_base_address <= i[16:14] == 0;
			st <= 1;
			sid <= $urandom;
			sub <= 20'($urandom);
			ia <= {$urandom, $urandom} >> ($urandom % 48);
			oa <= 52'({$urandom, $urandom} >> (12 + $urandom % 30));
			intermediate_phys_address <= 52'({$urandom, $urandom});
			ib <= 6'(36 + $urandom % 12);
			sb <= 6'(36 + $urandom % 12);
			send;
			judge(0);
		end
		wb(1, 5'h00, 32'h3);
		@(posedge clk_i);
		{table_base_address, byp, s2, oa, leaf, af, st} <= {55'h0, 3'b101};
		send;
		judge(1);
		wb(1, 5'h00, 32'h1);
		send;
		judge(0);
		@(posedge clk_i);
		{s2, cls, leaf, perm, st} <= 6'b101010;
		sid <= 32'h5A;
		send;
		judge(0);
		@(posedge clk_i);
		ia <= ia ^ 64'hFFF;
		send;
		chk("merged", 0, rv);
		wb(0, 5'h04, 0);
		chk("mergebit", 1, q[4]);
		@(posedge clk_i);
		st <= 1;
		send;
		judge(0);
		send;
		judge(0);
		wb(0, 5'h10, 0);
		chk("last", 8'h13, q[7:0]);
		wb(1, 5'h08, 0);
		a1 = irq;
		wb(1, 5'h08, 32'h1F);
		chk("irqmasked", 0, a1);
		chk("irqmask", 1, irq);
		wb(1, 5'h04, 32'h1F);
		wb(0, 5'h04, 0);
		chk("cleared", 0, q);
		chk("irqoff", 0, irq);
		for (n = 0; n < 100 && !ready; n++)
			@(posedge clk_i);
		repeat (2) @(posedge clk_i);
		chk("queue", recs, u_q.taken_o);
		report_and_stop();
	end
endmodule
bind tfer_top tfer_properties u_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .req_valid_i,
	.req_ready_o, .req_ttb_err_i, .req_from_ste_i, .req_bypass_i, .req_stage2_i, .req_stall_i,
	.req_impl_bits_i, .req_in_addr_i, .rec_valid_o, .rec_ready_i, .rec_data_o, .cfg_err_o,
	.cfg_err_ste_o, .af_update_o);
